// File: design/frt_pkg.sv
// package for the free-running timer counter block
// assumes a 32-bit apb slave at 40 mhz; offsets are byte addresses
package frt_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CNT_HIGH = 8'h00;
    localparam logic [7:0] OFF_CNT_LOW = 8'h04;
    localparam logic [7:0] OFF_ALT_HIGH = 8'h08;
    localparam logic [7:0] OFF_ALT_LOW = 8'h0C;
    localparam logic [7:0] OFF_CTRL = 8'h48;
    localparam logic [7:0] OFF_STATUS = 8'h4C;
    localparam logic [7:0] OFF_IRQ_EN = 8'h50;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h54;
    // field positions
    localparam int CTRL_OVF_IE_BIT = 5;
    localparam int STATUS_OVF_BIT = 5;
    localparam int IRQ_OVF_BIT = 0;
    // reset values and timing
    localparam logic [15:0] CNT_PRESET = 16'hFFFC;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam int STARTUP_CYCLES = 4064;
    localparam logic [12:0] STARTUP_W = 13'(STARTUP_CYCLES);
endpackage

// File: design/frt_timer.sv
// free-running 16-bit timer counter with byte-pair read views
// assumes an apb master on pclk; presetn is the device reset
// How it works
// R1: counter steps once per four pclk cycles through fixed prescaler.
// R2: any reset loads counter with fffc.
// R3: after power-on, counter holds preset until startup delay ends.
// R4: byte reads never change counter value or sequence.
// R5: primary byte locations are read-only; writes ignored.
// R6: primary low byte reads live until a high byte read.
// R7: high byte read latches low byte once until low byte read.
// R8: wrap from ffff to 0000 sets overflow flag.
// R9: interrupt requested while overflow flag and its enable are set.
// R10: flag cleared only by status read then primary low read.
// R11: alternate byte pair shows same counter with same latching.
// R12: alternate reads never touch flag or interrupts.
// R13: writes to alternate bytes are ignored.
// R14: high access suspends pair until low access completes it.
// R15: status register reports flags; control register holds enables.
// R16: software should mask interrupts across a two-byte read.
// R17: flag stays set across rollovers; counter keeps running.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module frt_timer #(
    parameter int STARTUP = frt_pkg::STARTUP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic timer_irq_req
);
    import frt_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic [1:0] presc;
        logic [12:0] startup;
        logic running;
        logic [7:0] pri_low_hold;
        logic pri_latched;
        logic [7:0] alt_low_hold;
        logic alt_latched;
        logic overflow_flag;
        logic status_armed;
        logic overflow_irq_enable;
        logic irq_status;
        logic irq_enable;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq_out;
        logic tirq_out;
    } frt_state_t;

    frt_state_t st;
    frt_state_t next_st;
    logic access;
    logic rd;
    logic wr;
    logic tick;
    logic wrap;

    ////////////////////////////////////////////////////////////////////
    // bus strobes; one wait state, and the pready cycle is no new access,
    // so a held penable cannot repeat a latch or flag side effect
    assign access = psel && penable && !st.ready;
    assign rd = access && !pwrite;
    assign wr = access && pwrite;
    assign tick = st.running && (st.presc == PRESCALE_LAST);
    assign wrap = tick && (st.count == CNT_TOP);

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.ready = 1'b0;
        next_st.slverr = 1'b0;
        // startup delay holds the counter at its preset [R3]
        if (!st.running) begin
            if (st.startup == 13'(STARTUP - 1)) begin
                next_st.running = 1'b1;
            end else begin
                next_st.startup = st.startup + 13'h0001;
            end
        end else begin
            next_st.presc = st.presc + 2'h1; // fixed divide by four [R1]
        end
        // count keeps going past every wrap [R1] [R17]
        if (tick) begin
            next_st.count = st.count + 16'h0001;
        end
        // apb access phase, answered with pready one cycle later
        if (access) begin
            next_st.ready = 1'b1;
            next_st.rdata = 32'h0000_0000;
        end
        // reads touch latches and the flag, never the count [R4]
        if (rd) begin
            if (paddr == OFF_CNT_HIGH) begin
                next_st.rdata[7:0] = st.count[15:8];
                if (!st.pri_latched) begin // first high read latches [R7]
                    next_st.pri_low_hold = st.count[7:0];
                    next_st.pri_latched = 1'b1; // suspends pair [R14]
                end
            end else if (paddr == OFF_CNT_LOW) begin
                // live low until high read latches [R6] [R7]
                next_st.rdata[7:0] = st.pri_latched ? st.pri_low_hold
                                                    : st.count[7:0];
                next_st.pri_latched = 1'b0; // low read completes [R14]
                if (st.status_armed) begin
                    next_st.overflow_flag = 1'b0; // [R10]
                    next_st.status_armed = 1'b0;
                end
            end else if (paddr == OFF_ALT_HIGH) begin
                // alternate view, same latching, no flag effect [R11] [R12]
                next_st.rdata[7:0] = st.count[15:8];
                if (!st.alt_latched) begin
                    next_st.alt_low_hold = st.count[7:0];
                    next_st.alt_latched = 1'b1;
                end
            end else if (paddr == OFF_ALT_LOW) begin
                next_st.rdata[7:0] = st.alt_latched ? st.alt_low_hold
                                                    : st.count[7:0];
                next_st.alt_latched = 1'b0; // [R11] [R14]
            end else if (paddr == OFF_CTRL) begin
                next_st.rdata[CTRL_OVF_IE_BIT] = st.overflow_irq_enable;
            end else if (paddr == OFF_STATUS) begin
                next_st.rdata[STATUS_OVF_BIT] = st.overflow_flag; // [R15]
                // arm clearing only if the flag was seen set
                next_st.status_armed = st.overflow_flag;
            end else if (paddr == OFF_IRQ_EN) begin
                next_st.rdata[IRQ_OVF_BIT] = st.irq_enable;
            end else if (paddr == OFF_IRQ_CLR) begin
                next_st.rdata[IRQ_OVF_BIT] = st.irq_status;
            end else begin
                next_st.slverr = 1'b1;
            end
        end
        // counter views take no writes [R5] [R13]
        if (wr) begin
            if (paddr == OFF_CTRL) begin
                next_st.overflow_irq_enable = pwdata[CTRL_OVF_IE_BIT]; // [R15]
            end else if (paddr == OFF_IRQ_EN) begin
                next_st.irq_enable = pwdata[IRQ_OVF_BIT];
            end else if (paddr == OFF_IRQ_CLR) begin
                if (pwdata[IRQ_OVF_BIT]) begin
                    next_st.irq_status = 1'b0;
                end
            end else if (paddr == OFF_CNT_HIGH || paddr == OFF_CNT_LOW ||
                         paddr == OFF_ALT_HIGH || paddr == OFF_ALT_LOW ||
                         paddr == OFF_STATUS) begin
                next_st.slverr = 1'b0;
            end else begin
                next_st.slverr = 1'b1;
            end
        end
        // rollover sets flag; set wins over a same-cycle clear [R8] [R17]
        if (wrap) begin
            next_st.overflow_flag = 1'b1;
            next_st.irq_status = 1'b1;
        end
        // request while flag and enable both set [R9]
        next_st.tirq_out = next_st.overflow_flag &&
                           next_st.overflow_irq_enable;
        next_st.irq_out = next_st.irq_status && next_st.irq_enable;
    end

    ////////////////////////////////////////////////////////////////////
    // every reset presets the counter [R2]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.count <= CNT_PRESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;
    assign irq = st.irq_out;
    assign timer_irq_req = st.tirq_out;
endmodule

// File: bench/frt_timer_properties.sv
// assertions on the apb timer counter block
// sees only frt_timer ports; bound at the foot
`timescale 1ns/1ps
module frt_timer_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic timer_irq_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // first access cycle; alternate view reads and counter view writes never clear the flag
    wire logic acc = psel && penable && !pready;
    wire logic view = paddr < 8'h10;
    wire logic alt = paddr == 8'h08 || paddr == 8'h0C;
    a_ready_after_take: assert property (acc |=> pready)
        else $error("pready missing after access");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside
        {8'h00, 8'h04, 8'h08, 8'h0C, 8'h48, 8'h4C, 8'h50, 8'h54}))
        else $error("pslverr wrong for address");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    a_reset_quiet: assert property ($rose(presetn) |->
        !irq && !timer_irq_req) else $error("interrupt high out of reset");
    a_alt_keeps_flag: assert property (acc && !pwrite && alt
        |=> (!$fell(timer_irq_req))[*2]) else $error("alt read cleared");
    a_write_keeps_flag: assert property (acc && pwrite && view
        |=> (!$fell(timer_irq_req))[*2]) else $error("view write cleared");
    a_req_fall_cause: assert property ($fell(timer_irq_req)
        |-> pready || $past(pready)) else $error("request fell unprompted");
    a_irq_fall_cause: assert property ($fell(irq) |->
        pready || $past(pready)) else $error("irq fell unprompted");
    cover property ($rose(timer_irq_req));
    cover property ($fell(timer_irq_req));
    cover property (pslverr);
endmodule
bind frt_timer frt_timer_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .timer_irq_req(timer_irq_req));

// File: bench/testbench.sv
// self-checking bench for frt_timer
// bench drives apb itself; startup shortened to 8 cycles
`timescale 1ns/1ps
module testbench;
    import frt_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, req, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int bad_count = 0;
    int n_compared = 0;
    frt_timer #(.STARTUP(8)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .timer_irq_req(req));
    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic end_of_test;
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; idle edge first so no signal is set twice
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
        if (i == 20) begin
            bad_count++;
            end_of_test;
        end
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd_chk(input logic [7:0] a, input int m, input int e);
        apb(0, a, 0);
        chk(rd & m, e);
    endtask
    task automatic lvl(input logic s, input logic e);
        repeat (2) @(posedge pclk);
        chk(32'(s), 32'(e));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic scn_preset;
        rd_chk(OFF_CNT_HIGH, 'hFF, 'hFF);
        repeat (40) @(posedge pclk);
        rd_chk(OFF_CNT_LOW, 'hFF, 'hFC);
    endtask
    task automatic scn_overflow;
        rd_chk(OFF_STATUS, 'h20, 'h20);
        apb(1, OFF_CTRL, 'h20);
        lvl(req, 1);
        apb(1, OFF_CNT_HIGH, 'hFFFF);
        apb(1, OFF_ALT_LOW, 'hFFFF);
        rd_chk(OFF_CNT_HIGH, 'hFF, 0);
        rd_chk(OFF_ALT_HIGH, 'hFF, 0);
        rd_chk(OFF_STATUS, 'h20, 'h20);
        apb(0, OFF_ALT_LOW, 0);
        lvl(req, 1);
        rd_chk(OFF_STATUS, 'h20, 'h20);
        apb(0, OFF_CNT_LOW, 0);
        lvl(req, 0);
        rd_chk(OFF_STATUS, 'h20, 0);
    endtask
    // two live alternate low reads 16 cycles apart differ by four counts
    task automatic scn_rate;
        logic [31:0] v;
        apb(0, OFF_ALT_LOW, 0);
        v = rd;
        repeat (12) @(posedge pclk);
        rd_chk(OFF_ALT_LOW, 'hFF, (v + 4) & 'hFF);
    endtask
    task automatic scn_irq;
        rd_chk(OFF_IRQ_CLR, 1, 1);
        chk(32'(irq), 0);
        apb(1, OFF_IRQ_EN, 1);
        lvl(irq, 1);
        apb(1, OFF_IRQ_CLR, 1);
        lvl(irq, 0);
        apb(0, 8'h60, 0);
        chk(32'(er), 1);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        scn_preset;
        scn_overflow;
        scn_rate;
        scn_irq;
        end_of_test;
    end
endmodule
